/* File: inc/ccsr_pkg.sv */
// Package for the processor control and status register block
package ccsr_pkg;
   localparam int          CCSR_W            = 32;
   localparam logic [7:0]  CORE_ID_DEFAULT   = 8'h5A; // Arbitrary value
   localparam logic [7:0]  REV_ID_DEFAULT    = 8'h01; // Arbitrary value
   localparam int          ID_HI             = 31;
   localparam int          ID_LO             = 16;
   localparam int          POWER_DOWN_REQUEST_HI           = 15;
   localparam int          POWER_DOWN_REQUEST_LO           = 10;
   localparam int          SAT_BIT           = 9;
   localparam int          ENDIAN_BIT        = 8;
   localparam int          PCC_HI            = 7;
   localparam int          PCC_LO            = 5;
   localparam int          DCC_HI            = 4;
   localparam int          DCC_LO            = 2;
   localparam int          SAVED_INTERRUPT_ENABLE_BIT          = 1;
   localparam int          GIE_BIT           = 0;
   localparam logic [2:0]  CACHE_MODE_RESET  = 3'h0;
   localparam logic [2:0]  CACHE_MODE_ALT    = 3'h2;
   localparam logic [5:0]  POWER_DOWN_REQUEST_NONE         = 6'h00;
   localparam logic [5:0]  POWER_DOWN_REQUEST_ONE_ENABLED  = 6'h09;
   localparam logic [5:0]  POWER_DOWN_REQUEST_ONE_ANY      = 6'h11;
   localparam logic [5:0]  POWER_DOWN_REQUEST_TWO          = 6'h1A;
   localparam logic [5:0]  POWER_DOWN_REQUEST_THREE        = 6'h1C;

   typedef enum logic [1:0] {
      CCSR_RUN   = 2'b00,
      CCSR_LP1   = 2'b01,
      CCSR_LP2   = 2'b10,
      CCSR_LP3   = 2'b11
   } ccsr_pwr_e;

   // Move-instruction access to the register
   typedef struct packed {
      logic              wrEn;
      logic [CCSR_W-1:0] wrData;
      logic              cond;
   } ccsr_move_s;
endpackage

/* File: hdl/ccsr_power_down.sv */
// Power-down request decoder and low-power state tracker
`timescale 1ns/1ps
`default_nettype none
module ccsr_power_down
   import ccsr_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       reqValid,
   input  wire logic [5:0] reqCode,
   input  wire logic       irqPending,
   input  wire logic       irqEnabledPending,
   output ccsr_pwr_e       pwrState
);
   ccsr_pwr_e stateQ;
   ccsr_pwr_e stateD;

   assign pwrState = stateQ;

   always_comb begin
      stateD = stateQ;
      case (stateQ)
         CCSR_RUN: begin
            if (reqValid) begin
               if (reqCode == POWER_DOWN_REQUEST_ONE_ENABLED || reqCode == POWER_DOWN_REQUEST_ONE_ANY) begin
                  stateD = CCSR_LP1;
               end else if (reqCode == POWER_DOWN_REQUEST_TWO) begin
                  stateD = CCSR_LP2;
               end else if (reqCode == POWER_DOWN_REQUEST_THREE) begin
                  stateD = CCSR_LP3;
               end
            end
         end
         CCSR_LP1: begin
            if (irqEnabledPending) begin
               stateD = CCSR_RUN;
            end
         end
         default: stateD = stateQ;
      endcase
   end

   // Wake mode for low-power state one is remembered at entry
   logic anyWakeQ;
   logic lp1Wake;
   assign lp1Wake = anyWakeQ ? irqPending : irqEnabledPending;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         stateQ   <= CCSR_RUN;
         anyWakeQ <= 1'b0;
      end else begin
         if (stateQ == CCSR_LP1) begin
            stateQ <= lp1Wake ? CCSR_RUN : CCSR_LP1;
         end else begin
            stateQ <= stateD;
         end
         if (stateQ == CCSR_RUN && reqValid) begin
            anyWakeQ <= (reqCode == POWER_DOWN_REQUEST_ONE_ANY);
         end
      end
   end
endmodule
`default_nettype wire

/* File: hdl/ccsr_top.sv */
// Processor control and status register with move-instruction access
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Upper sixteen bits read a fixed core and revision code; writes ignored.
// - Power-down request field always reads as zero.
// - Codes 001001 and 010001 enter state one; wake on enabled or any interrupt.
// - Codes 011010 and 011100 enter states two and three; reset only leaves.
// - Saturation flag sets when any functional unit saturates.
// - Only units set saturation; only the move instruction clears it.
// - A unit set beats a same-cycle move clear.
// - Saturation becomes visible one full cycle after the saturating operation.
// - Saturation from a false-condition instruction leaves the flag unchanged.
// - Byte-order bit is read-only; one means little-endian, the default.
// - Program cache mode accepts 000 or 010 only.
// - Data cache mode accepts 000 or 010 only.
// - Taking an interrupt copies global enable into saved enable; resets zero.
// - Global enable gates maskable interrupts; resets to zero.
// - Register reached only through the move instruction port.
module ccsr_top
   import ccsr_pkg::*;
#(
   parameter logic [7:0]  CORE_ID  = CORE_ID_DEFAULT,
   parameter logic [7:0]  REV_ID   = REV_ID_DEFAULT,
   parameter int          N_UNITS  = 8
)(
   input  wire logic               clk_sys,
   input  wire logic               reset_n,
   input  wire ccsr_move_s         moveReq,
   output logic [CCSR_W-1:0]       moveRdData,
   input  wire logic [N_UNITS-1:0] unitSaturate,
   input  wire logic [N_UNITS-1:0] unitCondTrue,
   input  wire logic               littleEndianPin,
   input  wire logic               interruptTaken,
   input  wire logic               interruptReturn,
   input  wire logic               maskableIrqPending,
   input  wire logic               nmiPending,
   output logic                    maskableIrqGated,
   output logic [2:0]              programCacheMode,
   output logic [2:0]              dataCacheMode,
   output ccsr_pwr_e               pwrState
);
   logic       satQ;
   logic       satPendQ;
   logic       gieQ;
   logic       pgieQ;
   logic [2:0] pccQ;
   logic [2:0] dccQ;
   logic       endianMeta;
   logic       endianSyncQ;
   logic       endianQ;

   // A move whose condition is false does nothing at all
   logic moveWrite;
   assign moveWrite = moveReq.wrEn & moveReq.cond;

   // Units whose condition is false cannot saturate the flag
   logic [N_UNITS-1:0] satValid;
   genvar gi;
   generate
      for (gi = 0; gi < N_UNITS; gi++) begin : g_unit
         assign satValid[gi] = unitSaturate[gi] & unitCondTrue[gi];
      end
   endgenerate
   logic anySat;
   assign anySat = |satValid;

   logic satClear;
   assign satClear = moveWrite & ~moveReq.wrData[SAT_BIT];

   logic [2:0] pccWr;
   logic [2:0] dccWr;
   logic       pccOk;
   logic       dccOk;
   assign pccWr = moveReq.wrData[PCC_HI:PCC_LO];
   assign dccWr = moveReq.wrData[DCC_HI:DCC_LO];
   assign pccOk = (pccWr == CACHE_MODE_RESET) || (pccWr == CACHE_MODE_ALT);
   assign dccOk = (dccWr == CACHE_MODE_RESET) || (dccWr == CACHE_MODE_ALT);

   logic gieD;
   logic pgieD;
   always_comb begin
      gieD  = gieQ;
      pgieD = pgieQ;
      if (interruptTaken) begin
         pgieD = gieQ;
         gieD  = 1'b0;
      end else if (interruptReturn) begin
         gieD  = pgieQ;
      end else if (moveWrite) begin
         gieD  = moveReq.wrData[GIE_BIT];
         pgieD = moveReq.wrData[SAVED_INTERRUPT_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         satQ     <= 1'b0;
         satPendQ <= 1'b0;
      end else begin
         satPendQ <= anySat;
         // Extra stage gives the one delay slot before visibility
         if (satPendQ) begin
            satQ <= 1'b1;
         end else if (satClear) begin
            satQ <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         gieQ  <= 1'b0;
         pgieQ <= 1'b0;
      end else begin
         gieQ  <= gieD;
         pgieQ <= pgieD;
      end
   end

   // Reserved cache codes are dropped, keeping the old mode
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pccQ <= CACHE_MODE_RESET;
         dccQ <= CACHE_MODE_RESET;
      end else begin
         if (moveWrite && pccOk) begin
            pccQ <= pccWr;
         end
         if (moveWrite && dccOk) begin
            dccQ <= dccWr;
         end
      end
   end

   // Byte-order strap comes from a pin, so it is synchronised first
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         endianMeta  <= 1'b1;
         endianSyncQ <= 1'b1;
         endianQ     <= 1'b1;
      end else begin
         endianMeta  <= littleEndianPin;
         endianSyncQ <= endianMeta;
         endianQ     <= endianSyncQ;
      end
   end

   assign maskableIrqGated = maskableIrqPending & gieQ;

   ccsr_power_down u_power_down (
      .clk_sys           (clk_sys),
      .reset_n           (reset_n),
      .reqValid          (moveWrite),
      .reqCode           (moveReq.wrData[POWER_DOWN_REQUEST_HI:POWER_DOWN_REQUEST_LO]),
      .irqPending        (maskableIrqPending | nmiPending),
      .irqEnabledPending (maskableIrqGated | nmiPending),
      .pwrState          (pwrState)
   );

   logic [CCSR_W-1:0] readWord;
   always_comb begin
      readWord                   = '0;
      readWord[ID_HI:ID_LO]      = {CORE_ID, REV_ID};
      readWord[POWER_DOWN_REQUEST_HI:POWER_DOWN_REQUEST_LO]  = POWER_DOWN_REQUEST_NONE;
      readWord[SAT_BIT]          = satQ;
      readWord[ENDIAN_BIT]       = endianQ;
      readWord[PCC_HI:PCC_LO]    = pccQ;
      readWord[DCC_HI:DCC_LO]    = dccQ;
      readWord[SAVED_INTERRUPT_ENABLE_BIT]         = pgieQ;
      readWord[GIE_BIT]          = gieQ;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         moveRdData <= '0;
      end else begin
         moveRdData <= readWord;
      end
   end

   assign programCacheMode = pccQ;
   assign dataCacheMode    = dccQ;
endmodule
`default_nettype wire

/* File: tb/ccsr_monitor.sv */
// Port checker for the control and status register
`timescale 1ns/1ps
`default_nettype none
module ccsr_monitor
   import ccsr_pkg::*;
#(
   parameter logic [7:0] CORE_ID = 8'h00,
   parameter logic [7:0] REV_ID  = 8'h00,
   parameter int         N_UNITS = 8
)(
   input wire logic               clk_sys,
   input wire logic               reset_n,
   input wire ccsr_move_s         moveReq,
   input wire logic [CCSR_W-1:0]  moveRdData,
   input wire logic [N_UNITS-1:0] unitSaturate,
   input wire logic [N_UNITS-1:0] unitCondTrue,
   input wire logic               interruptTaken,
   input wire logic               interruptReturn,
   input wire logic               maskableIrqPending,
   input wire logic               maskableIrqGated,
   input wire logic [2:0]         programCacheMode,
   input wire logic [2:0]         dataCacheMode,
   input wire ccsr_pwr_e          pwrState
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire satHit = |(unitSaturate & unitCondTrue);
   // Pending stage, flag and read register: exactly three edges after the hit
   sequence satShows;
      ##3 moveRdData[SAT_BIT];
   endsequence
   id_fixed_a: assert property ($past(reset_n, 2) |-> moveRdData[31:16] == {CORE_ID, REV_ID})
      else $error("id field wrong");
   power_down_request_zero_a: assert property (moveRdData[POWER_DOWN_REQUEST_HI:POWER_DOWN_REQUEST_LO] == 6'h00)
      else $error("power-down field not zero");
   sat_set_a: assert property (satHit |-> satShows)
      else $error("saturation not shown");
   sat_source_a: assert property ($rose(moveRdData[SAT_BIT]) |-> $past(satHit, 3))
      else $error("saturation set without unit");
   gie_gate_a: assert property (##1 $past(maskableIrqGated) == (moveRdData[GIE_BIT] && $past(maskableIrqPending)))
      else $error("irq gating wrong");
   saved_interrupt_enable_save_a: assert property (interruptTaken |-> ##2 moveRdData[SAVED_INTERRUPT_ENABLE_BIT] == $past(moveRdData[GIE_BIT]))
      else $error("saved enable not copied");
   gie_restore_a: assert property (interruptReturn && !interruptTaken |-> ##2 moveRdData[GIE_BIT] == $past(moveRdData[SAVED_INTERRUPT_ENABLE_BIT]))
      else $error("enable not restored");
   move_write_a: assert property (moveReq.wrEn && moveReq.cond && !interruptTaken && !interruptReturn
      |-> ##2 moveRdData[GIE_BIT] == $past(moveReq.wrData[GIE_BIT], 2))
      else $error("move write lost");
   cache_legal_a: assert property (((programCacheMode | dataCacheMode) & 3'h5) == 3'h0)
      else $error("reserved cache mode held");
   deep_sleep_a: assert property (pwrState inside {CCSR_LP2, CCSR_LP3} |=> $stable(pwrState))
      else $error("deep sleep left without reset");
endmodule
bind ccsr_top ccsr_monitor #(.CORE_ID(CORE_ID), .REV_ID(REV_ID), .N_UNITS(N_UNITS)) mon (.clk_sys,
   .reset_n, .moveReq, .moveRdData, .unitSaturate, .unitCondTrue, .interruptTaken,
   .interruptReturn, .maskableIrqPending, .maskableIrqGated, .programCacheMode,
   .dataCacheMode, .pwrState);
`default_nettype wire

/* File: tb/cpu_control_status_register_test.sv */
// Self-checking bench for the control and status register
`timescale 1ns/1ps
`default_nettype none
module cpu_control_status_register_test;
   import ccsr_pkg::*;
   localparam logic [31:0] IDW = {CORE_ID_DEFAULT, REV_ID_DEFAULT, 16'h0000};
   logic        clk_sys = 1'b0, reset_n = 1'b0, littleEndianPin = 1'b1;
   logic        interruptTaken = 1'b0, interruptReturn = 1'b0, nmiPending = 1'b0;
   logic        maskableIrqPending = 1'b0, maskableIrqGated;
   logic [7:0]  unitSaturate = 8'h00, unitCondTrue = 8'h00;
   logic [31:0] moveRdData;
   logic [2:0]  programCacheMode, dataCacheMode;
   ccsr_move_s  moveReq = '0;
   ccsr_pwr_e   pwrState;
   int          mismatches = 0, tests_run = 0;
   logic [5:0]  codes [6] = '{POWER_DOWN_REQUEST_NONE, POWER_DOWN_REQUEST_ONE_ENABLED, POWER_DOWN_REQUEST_ONE_ANY, POWER_DOWN_REQUEST_TWO, POWER_DOWN_REQUEST_THREE, 6'h3F};
   ccsr_pwr_e   sleepExp [6] = '{CCSR_RUN, CCSR_LP1, CCSR_LP1, CCSR_LP2, CCSR_LP3, CCSR_RUN};
   ccsr_pwr_e   wakeExp [6] = '{CCSR_RUN, CCSR_LP1, CCSR_RUN, CCSR_LP2, CCSR_LP3, CCSR_RUN};
   always #2.5 clk_sys = ~clk_sys;
   ccsr_top dut (.clk_sys, .reset_n, .moveReq, .moveRdData, .unitSaturate, .unitCondTrue,
      .littleEndianPin, .interruptTaken, .interruptReturn, .maskableIrqPending,
      .nmiPending, .maskableIrqGated, .programCacheMode, .dataCacheMode, .pwrState);
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic move(input logic [31:0] d, input logic c = 1'b1);
      step(1);
      moveReq <= '{1'b1, d, c};
      step(1);
      moveReq.wrEn <= 1'b0;
      step(3);
   endtask
   // A clear move lands in the cycle the delayed set takes effect
   task automatic saturate(input logic [7:0] cond, input logic clr);
      step(1);
      unitSaturate <= 8'h08;
      unitCondTrue <= cond;
      step(1);
      unitSaturate <= 8'h00;
      moveReq      <= '{clr, 32'h0000_0049, 1'b1};
      step(1);
      moveReq.wrEn <= 1'b0;
      step(5);
   endtask
   task automatic do_reset;
      step(1);
      reset_n <= 1'b0;
      step(10);
      reset_n <= 1'b1;
      step(4);
   endtask
   initial begin
      do_reset;
      check("reset image", moveRdData, IDW | 32'h0000_0100);
      move(32'hFFFF_FF4B);
      check("write image", moveRdData, IDW | 32'h0000_014B);
      check("cache modes", {26'h0, programCacheMode, dataCacheMode}, 32'h12);
      move(32'h0000_00FC);
      check("reserved cache", moveRdData, IDW | 32'h0000_0148);
      move(32'h0000_0000, 1'b0);
      check("false move", moveRdData, IDW | 32'h0000_0148);
      littleEndianPin <= 1'b0;
      step(6);
      check("big endian", moveRdData[8], 1'b0);
      littleEndianPin <= 1'b1;
      step(6);
      saturate(8'h00, 1'b0);
      check("false sat", moveRdData[9], 1'b0);
      saturate(8'hFF, 1'b0);
      check("sat set", moveRdData[9], 1'b1);
      // Flag must start clear so that a losing set would show
      move(32'h0000_0049);
      check("sat cleared", moveRdData[9], 1'b0);
      saturate(8'hFF, 1'b1);
      check("set over clear", moveRdData[9], 1'b1);
      move(32'h0000_0049);
      check("sat clear", moveRdData, IDW | 32'h0000_0149);
      maskableIrqPending <= 1'b1;
      step(2);
      check("gated irq", maskableIrqGated, 1'b1);
      interruptTaken <= 1'b1;
      step(1);
      interruptTaken <= 1'b0;
      step(3);
      check("irq taken", moveRdData[1:0], 2'b10);
      check("masked irq", maskableIrqGated, 1'b0);
      interruptReturn <= 1'b1;
      step(1);
      interruptReturn <= 1'b0;
      step(3);
      check("irq return", moveRdData[1:0], 2'b11);
      maskableIrqPending <= 1'b0;
      // Enable stays off so only the any-interrupt code wakes on a masked irq
      for (int i = 0; i < 6; i++) begin
         do_reset;
         move({16'h0000, codes[i], 10'h048});
         check("sleep state", pwrState, sleepExp[i]);
         maskableIrqPending <= 1'b1;
         step(3);
         check("masked wake", pwrState, wakeExp[i]);
         nmiPending <= 1'b1;
         step(3);
         check("nmi wake", pwrState, (i == 3 || i == 4) ? sleepExp[i] : CCSR_RUN);
         maskableIrqPending <= 1'b0;
         nmiPending <= 1'b0;
      end
      tally_and_finish;
   end
   initial begin
      step(2000);
      mismatches++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
